// ---- hdl/ssor_regs.sv ----
// Strap capture, strap status and operating override registers, reached
// through the control/data portal pair of the management register port.
// Assumes one request per cycle, never read and write in the same cycle.
`timescale 1ns/1ps
module ssor_regs (
    input wire logic clk,
    input wire logic srst,
    input wire ssor_pkg::ssor_strap_t strap_pins,
    input wire ssor_pkg::ssor_req_t mgmt_req,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic straps_valid,
    output logic led_style_single,
    output logic ref_clock_out_enable,
    output logic [3:0] adv_override,
    output logic wake_output_enable,
    output logic [1:0] wake_pin_select
);
    import ssor_pkg::*;

    // ----------------------------------------------------------------------
    // Strap synchroniser and capture
    // ----------------------------------------------------------------------
    ssor_strap_t sync1;
    ssor_strap_t sync2;
    ssor_strap_t sync3;
    ssor_strap_t strap_q;
    ssor_strap_t next_strap;
    logic pending;
    logic next_pending;
    logic capture_ev;
    logic [2:0] fill;

    always_ff @(posedge clk) begin
        if (srst) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            fill <= '0;
        end else begin
            sync1 <= strap_pins;
            sync2 <= sync1;
            sync3 <= sync2;
            fill <= {fill[1:0], 1'b1};
        end
    end

    // Straps are only trusted once the third stage holds a sampled pin value
    // and the last two stages agree. Without the fill marker the cleared
    // stages would agree at once and load zeros instead of the straps.
    assign capture_ev = pending && fill[2] && (sync2 == sync3);

    always_comb begin
        next_pending = pending;
        next_strap = strap_q;
        if (capture_ev) begin
            next_pending = 1'b0;
            next_strap = sync3;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pending <= 1'b1;
            strap_q <= '0;
        end else begin
            pending <= next_pending;
            strap_q <= next_strap;
        end
    end

    // ----------------------------------------------------------------------
    // Portal decode
    // ----------------------------------------------------------------------
    logic [15:0] ctrl_q;
    logic [15:0] addr_q;
    logic [15:0] cc_q;
    logic [15:0] om_q;
    logic [15:0] ws_q;
    logic [15:0] next_ctrl;
    logic [15:0] next_addr;
    logic [15:0] next_cc;
    logic [15:0] next_om;
    logic [15:0] next_ws;
    logic [15:0] next_rd_data;
    logic next_rd_valid;
    ssor_pfn_t pfn;
    logic data_mode;
    logic dev_hit;
    logic wr_ctrl;
    logic wr_data;
    logic rd_ctrl;
    logic rd_port;
    logic mmd_wr;
    logic cc_wr;
    logic om_wr;
    logic ws_wr;
    logic mmd_rd;
    logic step_addr;

    assign pfn = ssor_pfn_t'(ctrl_q[PFN_LSB +: 2]);
    assign data_mode = (pfn != PF_ADDR);
    assign dev_hit = (ctrl_q[DEV_LSB +: 5] == MMD_VENDOR_DEV);
    assign wr_ctrl = mgmt_req.wr && (mgmt_req.reg_idx == PORTAL_CTRL_IDX);
    assign wr_data = mgmt_req.wr && (mgmt_req.reg_idx == PORTAL_DATA_IDX);
    assign rd_ctrl = mgmt_req.rd && (mgmt_req.reg_idx == PORTAL_CTRL_IDX);
    assign rd_port = mgmt_req.rd && (mgmt_req.reg_idx == PORTAL_DATA_IDX);
    assign mmd_wr = wr_data && data_mode && dev_hit;
    assign mmd_rd = rd_port && data_mode && dev_hit;
    assign cc_wr = mmd_wr && (addr_q == REG_COMMON);
    assign om_wr = mmd_wr && (addr_q == REG_OPMODE);
    assign ws_wr = mmd_wr && (addr_q == REG_WAKE_SEL);
    // Post-increment lets a manager walk consecutive registers.
    assign step_addr = (wr_data && (pfn == PF_DATA_INC_RW ||
                                    pfn == PF_DATA_INC_W)) ||
                       (rd_port && pfn == PF_DATA_INC_RW);

    function automatic logic [15:0] mmd_read(
        input logic [15:0] a,
        input logic [15:0] cc,
        input logic [15:0] om,
        input logic [15:0] ws,
        input ssor_strap_t s
    );
        logic [15:0] v;
        v = '0;
        if (a == REG_COMMON) begin
            v = cc;
        end else if (a == REG_STRAP) begin
            v[ST_LED] = s.led_style;
            v[ST_CLK] = s.clk_en;
            v[ST_ADDR_LSB +: 3] = s.addr;
        end else if (a == REG_OPMODE) begin
            v = om;
        end else if (a == REG_WAKE_SEL) begin
            v = ws;
        end
        return v;
    endfunction : mmd_read

    // ----------------------------------------------------------------------
    // Register next state
    // ----------------------------------------------------------------------
    always_comb begin
        next_ctrl = ctrl_q;
        next_addr = addr_q;
        next_cc = cc_q;
        next_om = om_q;
        next_ws = ws_q;
        next_rd_data = rd_data;
        next_rd_valid = 1'b0;
        if (wr_ctrl) begin
            next_ctrl = mgmt_req.wdata;
        end
        if (wr_data && !data_mode) begin
            next_addr = mgmt_req.wdata;
        end else if (step_addr) begin
            next_addr = addr_q + ADDR_STEP;
        end
        if (cc_wr) begin
            // The override bit is never stored, so it always reads zero.
            next_cc = mgmt_req.wdata & CC_RW_MASK;
            next_cc[CC_LED_STAT] = mgmt_req.wdata[CC_LED_OVR];
        end
        if (om_wr) begin
            next_om = mgmt_req.wdata;
        end
        if (ws_wr) begin
            next_ws = mgmt_req.wdata;
        end
        if (rd_ctrl) begin
            next_rd_data = ctrl_q;
            next_rd_valid = 1'b1;
        end else if (mgmt_req.rd) begin
            next_rd_valid = 1'b1;
            next_rd_data = '0;
            if (rd_port && !data_mode) begin
                next_rd_data = addr_q;
            end else if (mmd_rd) begin
                next_rd_data = mmd_read(addr_q, cc_q, om_q, ws_q, strap_q);
            end
        end
        // Strap-derived reset values win over a racing write.
        if (capture_ev) begin
            next_cc = CC_RESET;
            next_cc[CC_LED_STAT] = sync3.led_style;
            next_cc[CC_CLK_EN] = sync3.clk_en;
            next_om = OM_RESET;
            next_om[OM_CAP_LSB +: 4] = sync3.mode;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_q <= PORTAL_RESET;
            addr_q <= PORTAL_RESET;
            cc_q <= CC_RESET;
            om_q <= OM_RESET;
            ws_q <= WS_RESET;
            rd_data <= '0;
            rd_valid <= 1'b0;
        end else begin
            ctrl_q <= next_ctrl;
            addr_q <= next_addr;
            cc_q <= next_cc;
            om_q <= next_om;
            ws_q <= next_ws;
            rd_data <= next_rd_data;
            rd_valid <= next_rd_valid;
        end
    end

    // ----------------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------------
    assign straps_valid = !pending;
    assign led_style_single = cc_q[CC_LED_STAT];
    assign ref_clock_out_enable = cc_q[CC_CLK_EN];
    // One-hot use is software's duty; all four bits go out as written.
    assign adv_override = om_q[OM_CAP_LSB +: 4];
    assign wake_output_enable = om_q[OM_WAKE_EN];
    assign wake_pin_select = ws_q[WS_SEL_LSB +: 2];

    // ----------------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence s_cc_write;
        cc_wr && !capture_ev;
    endsequence

    sequence s_capture;
        capture_ev;
    endsequence

    a_led_status_follow: assert property (
        s_cc_write |=> led_style_single == $past(mgmt_req.wdata[CC_LED_OVR])
    ) else $error("LED status did not follow override write");

    a_led_ovr_zero: assert property (
        (mmd_rd && addr_q == REG_COMMON) |=> rd_valid && !rd_data[CC_LED_OVR]
    ) else $error("LED override field read back nonzero");

    a_clk_strap_reset: assert property (
        s_capture |=> ref_clock_out_enable == $past(sync3.clk_en)
    ) else $error("Clock output enable did not load strap");

    a_strap_status_read: assert property (
        (mmd_rd && addr_q == REG_STRAP) |=>
            rd_data[ST_LED] == $past(strap_q.led_style) &&
            rd_data[15:8] == 8'h00
    ) else $error("Strap status LED bit wrong");

    a_clk_strap_read: assert property (
        (mmd_rd && addr_q == REG_STRAP) |=>
            rd_data[ST_CLK] == $past(strap_q.clk_en) && !rd_data[6]
    ) else $error("Strap status clock bit wrong");

    a_addr_strap_read: assert property (
        (mmd_rd && addr_q == REG_STRAP) |=>
            rd_data[4:0] == {2'b00, $past(strap_q.addr)}
    ) else $error("Strap status address field wrong");

    a_mode_strap_reset: assert property (
        s_capture |=> adv_override == $past(sync3.mode) ##1 !pending
    ) else $error("Capability overrides did not load mode strap");

    a_opmode_write: assert property (
        (om_wr && !capture_ev) |=>
            adv_override == $past(mgmt_req.wdata[OM_CAP_LSB +: 4])
    ) else $error("Capability override write lost");

    a_wake_enable: assert property (
        s_capture |=> !wake_output_enable
    ) else $error("Wake enable not cleared at strap load");

    a_wake_select: assert property (
        ws_wr |=> wake_pin_select == $past(mgmt_req.wdata[WS_SEL_LSB +: 2])
    ) else $error("Wake pin selector did not update");

    a_strap_hold: assert property (
        !capture_ev |=> $stable(strap_q)
    ) else $error("Captured straps changed after capture");

    // A capture sooner than three edges after reset would load cleared stages.
    a_capture_delay: assert property (
        s_capture |-> !$past(srst, 3)
    ) else $error("Straps captured before synchroniser filled");

    a_clk_en_write: assert property (
        s_cc_write |=>
            ref_clock_out_enable == $past(mgmt_req.wdata[CC_CLK_EN])
    ) else $error("Clock output enable write lost");

    a_wake_en_write: assert property (
        (om_wr && !capture_ev) |=>
            wake_output_enable == $past(mgmt_req.wdata[OM_WAKE_EN])
    ) else $error("Wake enable write lost");

    a_ctrl_readback: assert property (
        rd_ctrl |=> rd_valid && rd_data == $past(ctrl_q)
    ) else $error("Control portal did not read back as written");

    a_unmapped_zero: assert property (
        (mgmt_req.rd && !rd_ctrl && !rd_port) |=>
            rd_valid && rd_data == 16'h0000
    ) else $error("Unmapped register index read nonzero");

endmodule : ssor_regs

// ---- shared/ssor_pkg.sv ----
// Constants, types and field layout for the strap status/override bank.
// Assumes a register port that carries single-cycle portal reads/writes.
// Functional notes
// - LED status bit is read-only, loads strap, follows override writes.
// - Control bit 1 is read/write clock output enable, resets to strap.
// - Strap status bit 7 returns captured LED style strap, read-only.
// - Strap status bit 5 returns captured clock enable strap, read-only.
// - Strap status bits 2:0 return address strap; upper bits read zero.
// - Override bit 15 forces advertising every speed and duplex capability.
// - Override bit 14 advertises everything except gigabit half duplex.
// - Override bit 13 restricts advertising to gigabit full and half duplex.
// - Override bit 12 restricts advertising to gigabit full duplex.
// - The four capability override bits reset from the operating mode strap.
// - Override bit 10 enables wake output on the shared pin, resets zero.
// - Shared pin function depends on wake enable and selector bits 15:14.
// - LED override field is write-only, reads zero, updates LED status.
package ssor_pkg;

    // ----------------------------------------------------------------------
    // Portal and register addresses
    // ----------------------------------------------------------------------
    localparam logic [4:0] PORTAL_CTRL_IDX = 5'h0d;
    localparam logic [4:0] PORTAL_DATA_IDX = 5'h0e;
    localparam logic [4:0] MMD_VENDOR_DEV = 5'h02;
    localparam logic [15:0] REG_COMMON = 16'h0000;
    localparam logic [15:0] REG_STRAP = 16'h0001;
    localparam logic [15:0] REG_OPMODE = 16'h0002;
    localparam logic [15:0] REG_WAKE_SEL = 16'h0010;
    localparam logic [15:0] ADDR_STEP = 16'h0001;

    // ----------------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------------
    localparam int PFN_LSB = 14;
    localparam int DEV_LSB = 0;
    localparam int CC_LED_OVR = 4;
    localparam int CC_LED_STAT = 3;
    localparam int CC_CLK_EN = 1;
    localparam int ST_LED = 7;
    localparam int ST_CLK = 5;
    localparam int ST_ADDR_LSB = 0;
    localparam int OM_CAP_LSB = 12;
    localparam int OM_WAKE_EN = 10;
    localparam int WS_SEL_LSB = 14;

    // ----------------------------------------------------------------------
    // Write masks and reset values
    // ----------------------------------------------------------------------
    localparam logic [15:0] CC_RW_MASK = 16'hffe7;
    localparam logic [15:0] CC_RESET = 16'h0000;
    localparam logic [15:0] OM_RESET = 16'h0000;
    localparam logic [15:0] WS_RESET = 16'h0000;
    localparam logic [15:0] PORTAL_RESET = 16'h0000;

    typedef enum logic [1:0] {
        PF_ADDR,
        PF_DATA,
        PF_DATA_INC_RW,
        PF_DATA_INC_W
    } ssor_pfn_t;

    typedef struct packed {
        logic led_style;
        logic clk_en;
        logic [2:0] addr;
        logic [3:0] mode;
    } ssor_strap_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] reg_idx;
        logic [15:0] wdata;
    } ssor_req_t;

endpackage : ssor_pkg

// ---- dv/ssor_mgr_model.sv ----
// Station manager model that drives the strap bank register port.
// Assumes the bank samples one request per rising edge of clk.
`timescale 1ns/1ps
module ssor_mgr_model (
    input wire logic clk,
    output ssor_pkg::ssor_req_t mgmt_req
);
    import ssor_pkg::*;

    initial begin
        mgmt_req = '0;
    end

    // Idle cycles carry inverted data so a stale word never looks live.
    task automatic acc(input logic w, input logic r, input logic [4:0] idx,
                       input logic [15:0] d);
        @(posedge clk);
        mgmt_req <= '{wr: w, rd: r, reg_idx: idx, wdata: d};
        @(posedge clk);
        mgmt_req <= '{wr: 1'b0, rd: 1'b0, reg_idx: idx, wdata: ~d};
    endtask : acc

    // Address mode, register number, data mode, then the data access.
    task automatic mmd(input logic [15:0] ctl, input logic [15:0] ra,
                       input logic w, input logic [15:0] d);
        acc(1'b1, 1'b0, PORTAL_CTRL_IDX, {11'h000, MMD_VENDOR_DEV});
        acc(1'b1, 1'b0, PORTAL_DATA_IDX, ra);
        acc(1'b1, 1'b0, PORTAL_CTRL_IDX, ctl);
        acc(w, ~w, PORTAL_DATA_IDX, d);
    endtask : mmd
endmodule : ssor_mgr_model

// ---- dv/testbench.sv ----
// Self-checking bench for the strap status and override registers.
// Assumes the manager model is the only source of register requests.
`timescale 1ns/1ps
module testbench;
    import ssor_pkg::*;

    logic clk;
    logic srst;
    ssor_strap_t strap_pins;
    ssor_req_t mgmt_req;
    logic [15:0] rd_data;
    logic rd_valid;
    logic straps_valid;
    logic led_style_single;
    logic ref_clock_out_enable;
    logic [3:0] adv_override;
    logic wake_output_enable;
    logic [1:0] wake_pin_select;
    logic [15:0] exp_q[$];
    logic [15:0] st;
    logic [15:0] d;
    int n_errors = 0;
    int checks = 0;

    ssor_regs i_dut (.clk(clk), .srst(srst), .strap_pins(strap_pins),
        .mgmt_req(mgmt_req), .rd_data(rd_data), .rd_valid(rd_valid),
        .straps_valid(straps_valid), .led_style_single(led_style_single),
        .ref_clock_out_enable(ref_clock_out_enable),
        .adv_override(adv_override), .wake_output_enable(wake_output_enable),
        .wake_pin_select(wake_pin_select));
    ssor_mgr_model i_mgr (.clk(clk), .mgmt_req(mgmt_req));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic end_sim;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Read answers are matched oldest first against the noted values.
    always @(posedge clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("[FAIL] %0t read answer nobody asked for", $time);
            end else begin
                chk(rd_data, exp_q.pop_front());
            end
        end
    end

    task automatic wr(input logic [15:0] ra, input logic [15:0] v);
        i_mgr.mmd(16'h4002, ra, 1'b1, v);
        @(negedge clk);
    endtask : wr

    task automatic rd(input logic [15:0] ra, input logic [15:0] e);
        exp_q.push_back(e);
        i_mgr.mmd(16'h4002, ra, 1'b0, 16'h0000);
    endtask : rd

    // ----------------------------------------------------------------
    // Stimulus: two reset passes, each with fresh random straps.
    // ----------------------------------------------------------------
    initial begin
        srst = 1'b1;
        strap_pins = '0;
        void'($urandom(32'hb4f5383e));
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            srst <= 1'b1;
            strap_pins <= ssor_strap_t'(9'($urandom));
            repeat (5) @(posedge clk);
            srst <= 1'b0;
            for (int i = 0; i < 20 && straps_valid !== 1'b1; i++) begin
                @(negedge clk);
            end
            if (straps_valid !== 1'b1) begin
                n_errors++;
                $display("[FAIL] %0t straps never captured", $time);
                end_sim();
            end
            @(negedge clk);
            st = {8'h00, strap_pins.led_style, 1'b0, strap_pins.clk_en,
                  2'b00, strap_pins.addr};
            chk(16'(led_style_single), 16'(strap_pins.led_style));
            chk(16'(ref_clock_out_enable), 16'(strap_pins.clk_en));
            chk(16'(adv_override), 16'(strap_pins.mode));
            chk(16'(wake_output_enable), 16'h0000);
            rd(REG_STRAP, st);
            rd(REG_COMMON, {12'h000, strap_pins.led_style, 1'b0,
                            strap_pins.clk_en, 1'b0});
            rd(REG_OPMODE, {strap_pins.mode, 12'h000});
            wr(REG_STRAP, 16'hffff);
            rd(REG_STRAP, st);
            wr(REG_COMMON, 16'h0010);
            chk(16'(led_style_single), 16'h0001);
            rd(REG_COMMON, {12'h000, 3'b100, strap_pins.clk_en}
                           & 16'h000a);
            wr(REG_COMMON, 16'h0000);
            chk(16'(led_style_single), 16'h0000);
            chk(16'(ref_clock_out_enable), 16'h0000);
            wr(REG_COMMON, 16'hffff);
            chk(16'(ref_clock_out_enable), 16'h0001);
            rd(REG_COMMON, 16'hffef);
            for (int i = 0; i < 4; i++) begin
                d = 16'h0400 | (16'h1000 << i) | 16'(9'($urandom) & 9'h1ff);
                wr(REG_OPMODE, d);
                chk(16'(adv_override), 16'(4'h1 << i));
                chk(16'(wake_output_enable), 16'h0001);
                rd(REG_OPMODE, d);
            end
            wr(REG_OPMODE, 16'h0000);
            chk(16'(wake_output_enable), 16'h0000);
            d = 16'($urandom);
            wr(REG_WAKE_SEL, d);
            chk(16'(wake_pin_select), 16'(d[15:14]));
            rd(REG_WAKE_SEL, d);
            exp_q.push_back(16'h0000);
            i_mgr.acc(1'b0, 1'b1, 5'h03, 16'h0000);
            i_mgr.acc(1'b1, 1'b0, PORTAL_CTRL_IDX, 16'h4001);
            exp_q.push_back(16'h0000);
            i_mgr.acc(1'b0, 1'b1, PORTAL_DATA_IDX, 16'h0000);
            exp_q.push_back(st);
            exp_q.push_back(16'h0000);
            i_mgr.mmd(16'h8002, REG_STRAP, 1'b0, 16'h0000);
            i_mgr.acc(1'b0, 1'b1, PORTAL_DATA_IDX, 16'h0000);
            repeat (3) @(negedge clk);
            chk(16'(exp_q.size()), 16'h0000);
        end
        end_sim();
    end
endmodule : testbench
